// ### hdl/lts_consts.svh
`ifndef LTS_CONSTS_SVH
`define LTS_CONSTS_SVH
// ==========================================
// Register indexes and layout
`define LTS_IDX_LINK_CFG 10'h008
`define LTS_IDX_STRAP_SEL 10'h067
`define LTS_HOLD_LSB 21
`define LTS_GRST_BIT 31
`define LTS_CODE_MSB 4
`define LTS_LINK_CFG_RST 32'h07e00000
`define LTS_STRAP_SEL_RST 32'h00000000
// ==========================================
// Strap patterns (pin levels, bit 4 first)
`define LTS_PAT_X1 3'h2
`define LTS_PAT_42 3'h0
`define LTS_PAT_411 3'h1
`define LTS_PAT_222 3'h5
`define LTS_PAT_2211 3'h4
`define LTS_PAT_21111 3'h3
`define LTS_PAT_SW 2'h3
// ==========================================
// Topology read-back codes
`define LTS_CODE_X1 5'h0b
`define LTS_CODE_42 5'h01
`define LTS_CODE_411 5'h02
`define LTS_CODE_222 5'h0c
`define LTS_CODE_2211 5'h0a
`define LTS_CODE_21111 5'h04
// ==========================================
// Per-topology maps: lane nibble = port, port nibble = device
`define LTS_ACT_X1 6'h3f
`define LTS_ACT_42 6'h03
`define LTS_ACT_411 6'h07
`define LTS_ACT_222 6'h07
`define LTS_ACT_2211 6'h0f
`define LTS_ACT_21111 6'h1f
`define LTS_ACT_NONE 6'h00
`define LTS_LANE_X1 24'h543210
`define LTS_LANE_42 24'h110000
`define LTS_LANE_411 24'h210000
`define LTS_LANE_222 24'h221100
`define LTS_LANE_2211 24'h321100
`define LTS_LANE_21111 24'h432100
`define LTS_LANE_NONE 24'hffffff
`define LTS_DEV_X1 24'ha97654
`define LTS_DEV_42 24'h000094
`define LTS_DEV_411 24'h000a94
`define LTS_DEV_222 24'h000964
`define LTS_DEV_2211 24'h00a964
`define LTS_DEV_21111 24'h0a9764
`define LTS_DEV_NONE 24'h000000
`endif

// ### hdl/lts_pkg.sv
`default_nettype none
package lts_pkg;
	// Power-up sequence of the loader
	typedef enum logic [1:0] {
		LTS_ST_RESET,
		LTS_ST_SAMPLE,
		LTS_ST_RUN
	} lts_state_t;
	// One topology: active ports, lane steering, device numbers
	typedef struct packed {
		logic [5:0] active;
		logic [23:0] lanes;
		logic [23:0] devs;
	} lts_map_t;
endpackage
`default_nettype wire

// ### hdl/lts_top.sv
// Function
// - 2:2:1:1 forms four ports on lanes
// - 2:2:1:1 devices 4,6,9,10; holds 21-24
// - 2:1:1:1:1 forms five ports on lanes
// - 2:1:1:1:1 devices 4,6,7,9,10; holds 21-25
// - No training while port hold set
// - Straps default, software may override
// - Three active-low pulled-up topology straps
// - Patterns 010,000,001 give 01011,00001,00010
// - Patterns 101,100,011 give 01100,01010,00100
// - Upper straps high: use software code
// - Write overrides; field reads selected code
// - All hold bits set after reset
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "lts_consts.svh"
module lts_top (
	input wire logic core_clk, // 100 MHz clock
	input wire logic reset_n, // Async reset, low
	input wire logic clk_en, // Freezes all state when low
	input wire logic [2:0] topology_select_pins, // Straps, pin 4 first
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	output logic [4:0] topology_code, // Selected code
	output logic core_global_reset, // Port core reset
	output logic [5:0] port_active, // Port exists
	output logic [5:0] port_train_en, // Port may train
	output logic [23:0] port_dev_num, // Device number per port
	output logic [23:0] lane_port // Port per lane, f unused
);

	// ==========================================
	// Reset synchroniser
	logic rst_meta_r;
	logic rst_n_r;

	// Release through two flops, assert at once; the clock
	// enable also stalls the release, so a frozen block stays
	// in reset until its clock runs again
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else if (clk_en) begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	// ==========================================
	// Helpers

	// Byte address of a register index
	function automatic logic [11:0] reg_addr(input logic [9:0] idx);
		reg_addr = {idx, 2'b00};
	endfunction

	// Full-word address match against one register index
	function automatic logic addr_hit(input logic [11:0] a, input logic [9:0] idx);
		addr_hit = a == reg_addr(idx);
	endfunction

	// Ports allowed to train: present, released, core not in reset
	function automatic logic [5:0] train_mask(input logic [5:0] act, input logic [5:0] hld, input logic grst);
		train_mask = act & ~hld & {6{!grst}};
	endfunction

	// Strap pattern to topology code
	function automatic logic [4:0] strap_code(input logic [2:0] pat);
		logic [4:0] c;
		c = `LTS_CODE_X1;
		unique case (pat)
			`LTS_PAT_X1: c = `LTS_CODE_X1;
			`LTS_PAT_42: c = `LTS_CODE_42;
			`LTS_PAT_411: c = `LTS_CODE_411;
			`LTS_PAT_222: c = `LTS_CODE_222;
			`LTS_PAT_2211: c = `LTS_CODE_2211;
			`LTS_PAT_21111: c = `LTS_CODE_21111;
			default: c = `LTS_CODE_X1;
		endcase
		strap_code = c;
	endfunction

	// Topology code to port and lane map
	function automatic lts_pkg::lts_map_t topo_map(input logic [4:0] code);
		lts_pkg::lts_map_t m;
		m = '{`LTS_ACT_NONE, `LTS_LANE_NONE, `LTS_DEV_NONE};
		case (code)
			`LTS_CODE_X1:
				m = '{`LTS_ACT_X1, `LTS_LANE_X1, `LTS_DEV_X1};
			`LTS_CODE_42:
				m = '{`LTS_ACT_42, `LTS_LANE_42, `LTS_DEV_42};
			`LTS_CODE_411:
				m = '{`LTS_ACT_411, `LTS_LANE_411, `LTS_DEV_411};
			`LTS_CODE_222:
				m = '{`LTS_ACT_222, `LTS_LANE_222, `LTS_DEV_222};
			`LTS_CODE_2211:
				m = '{`LTS_ACT_2211, `LTS_LANE_2211, `LTS_DEV_2211};
			`LTS_CODE_21111:
				m = '{`LTS_ACT_21111, `LTS_LANE_21111, `LTS_DEV_21111};
			// Unsupported software code: no port comes up
			default:
				m = '{`LTS_ACT_NONE, `LTS_LANE_NONE, `LTS_DEV_NONE};
		endcase
		topo_map = m;
	endfunction

	// ==========================================
	// Strap capture
	lts_pkg::lts_state_t state_r;
	logic [2:0] strap_r;

	// Wait one cycle after release, then take straps once;
	// the idle cycle lets the pins settle after reset
	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r <= lts_pkg::LTS_ST_RESET;
		end else if (clk_en) begin
			unique case (state_r)
				lts_pkg::LTS_ST_RESET: state_r <= lts_pkg::LTS_ST_SAMPLE;
				lts_pkg::LTS_ST_SAMPLE: state_r <= lts_pkg::LTS_ST_RUN;
				lts_pkg::LTS_ST_RUN: state_r <= lts_pkg::LTS_ST_RUN;
			endcase
		end
	end

	logic take_straps;

	// Single strobe: the straps are never looked at again, so
	// a pin that moves later cannot disturb a running core
	assign take_straps = clk_en && state_r == lts_pkg::LTS_ST_SAMPLE;

	// Pull-ups make an open strap read high; reset value is
	// the all-single-lane pattern until the sample lands
	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			strap_r <= `LTS_PAT_X1;
		end else if (take_straps) begin
			strap_r <= topology_select_pins;
		end
	end

	// ==========================================
	// APB decode
	logic hit_cfg;
	logic hit_sel;
	logic setup;
	logic wr_acc;

	// Full word compare; unused address bits never alias
	assign hit_cfg = addr_hit(paddr, `LTS_IDX_LINK_CFG);
	assign hit_sel = addr_hit(paddr, `LTS_IDX_STRAP_SEL);
	// Setup starts every transfer; access only completes it
	assign setup = psel && !penable;
	// Write lands at the access edge that sees pready
	assign wr_acc = psel && penable && pwrite && pready;

	// ==========================================
	// Write strobes and read capture
	logic wr_cfg;
	logic wr_sel;
	logic rd_setup;

	// One strobe per register; clock enable folded in here
	assign wr_cfg = clk_en && wr_acc && hit_cfg;
	assign wr_sel = clk_en && wr_acc && hit_sel;
	// Read data is fetched in setup so it stands with ready
	assign rd_setup = clk_en && setup && !pwrite;

	// ==========================================
	// Registers
	logic [31:0] link_cfg_r;
	logic [31:0] strap_sel_r;
	logic sw_written_r;

	// Holds start set so no port trains before firmware;
	// every bit is plain storage, read back as written
	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			link_cfg_r <= `LTS_LINK_CFG_RST;
		end else if (wr_cfg) begin
			link_cfg_r <= pwdata;
		end
	end

	// Software code field; unsupported codes are stored as
	// written and simply bring no port up
	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			strap_sel_r <= `LTS_STRAP_SEL_RST;
		end else if (wr_sel) begin
			strap_sel_r <= pwdata;
		end
	end

	// Any write to the code register arms the override until the next reset, so
	// the straps can never swap the topology back
	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			sw_written_r <= 1'b0;
		end else if (wr_sel) begin
			sw_written_r <= 1'b1;
		end
	end

	// ==========================================
	// Topology selection
	logic [4:0] sel_code;
	logic strap_sw;
	logic use_sw;

	// Upper two straps high hand the choice to software
	assign strap_sw = strap_r[2:1] == `LTS_PAT_SW;
	// Software code wins on that pattern or after any code register write
	assign use_sw = strap_sw || sw_written_r;
	// Straps are the source while software is silent and the upper two straps are not both high
	assign sel_code = use_sw ? strap_sel_r[`LTS_CODE_MSB:0] : strap_code(strap_r);

	// ==========================================
	// APB answer
	logic [31:0] rd_nxt;

	// Read mux; selected code replaces stored code bits
	always_comb begin
		rd_nxt = '0;
		if (hit_cfg) begin
			rd_nxt = link_cfg_r;
		end else if (hit_sel) begin
			rd_nxt = strap_sel_r;
			rd_nxt[`LTS_CODE_MSB:0] = sel_code;
		end
	end

	// One-cycle answer: ready rises in every access phase,
	// so the master never sees a wait state
	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pready <= 1'b0;
		end else if (clk_en) begin
			pready <= setup;
		end
	end

	// Error for any address outside the two registers;
	// writes there are dropped, reads return zero
	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pslverr <= setup && !(hit_cfg || hit_sel);
		end
	end

	// Read data held between reads to save bus toggling
	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			prdata <= '0;
		end else if (rd_setup) begin
			prdata <= rd_nxt;
		end
	end

	// ==========================================
	// Port outputs
	lts_pkg::lts_map_t map;
	logic [5:0] hold;
	logic core_rst_nxt;
	logic run_en;

	assign map = topo_map(sel_code);
	assign hold = link_cfg_r[`LTS_HOLD_LSB +: 6];
	// Firmware keeps this set across a topology change
	assign core_rst_nxt = link_cfg_r[`LTS_GRST_BIT];
	// Outputs wait for the straps; before that the code
	// is not trusted and every port stays down
	assign run_en = clk_en && state_r == lts_pkg::LTS_ST_RUN;

	// Selected code, strap or software, as seen by the core
	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			topology_code <= `LTS_CODE_X1;
		end else if (run_en) begin
			topology_code <= sel_code;
		end
	end

	// Core reset passed out; here it also gates training
	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			core_global_reset <= 1'b1;
		end else if (run_en) begin
			core_global_reset <= core_rst_nxt;
		end
	end

	// Ports the topology forms; unused ones stay dark
	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			port_active <= `LTS_ACT_NONE;
		end else if (run_en) begin
			port_active <= map.active;
		end
	end

	// Training gate: hold bit, core reset and presence all count
	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			port_train_en <= `LTS_ACT_NONE;
		end else if (run_en) begin
			port_train_en <= train_mask(map.active, hold, core_rst_nxt);
		end
	end

	// Fixed device number per port, zero where unused
	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			port_dev_num <= `LTS_DEV_NONE;
		end else if (run_en) begin
			port_dev_num <= map.devs;
		end
	end

	// Lane steering; an unassigned lane reads all ones
	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			lane_port <= `LTS_LANE_NONE;
		end else if (run_en) begin
			lane_port <= map.lanes;
		end
	end

endmodule
`default_nettype wire

// ### sim/lts_straps.sv
`timescale 1ns/1ns
`default_nettype none
module lts_straps (
	input wire logic [2:0] strap_low, // Fitted pull-downs
	output logic [2:0] pins // Strap levels
);
	// Internal pull-up wins unless strapped low
	assign pins = ~strap_low;
endmodule
`default_nettype wire

// ### sim/lts_chk.sv
`timescale 1ns/1ns
`default_nettype none
module lts_chk (
	input wire logic core_clk, // Clock
	input wire logic reset_n, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic [11:0] paddr, // Address
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic [4:0] topology_code, // Code
	input wire logic core_global_reset, // Core reset
	input wire logic [5:0] port_active, // Ports
	input wire logic [5:0] port_train_en // Training
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// Outputs may lag a cause by one edge, hence the stability guards
	setup_ack_a: assert property (psel && !penable |=> pready) else $error("ack");
	ack_pulse_a: assert property (pready |=> !pready) else $error("pulse");
	err_decode_a: assert property (pready |-> pslverr == !(paddr == 12'h020 || paddr == 12'h19c))
		else $error("err");
	err_only_a: assert property (pslverr |-> pready) else $error("stray");
	idle_port_a: assert property ($stable(port_active) && $stable(core_global_reset) |->
		(port_train_en & ~port_active) == 6'h00 && !(core_global_reset && |port_train_en)) else $error("idle");
	map_2211_a: assert property (topology_code == 5'h0a && $stable(topology_code) |-> port_active == 6'h0f)
		else $error("2211");
	map_21111_a: assert property (topology_code == 5'h04 && $stable(topology_code) |-> port_active == 6'h1f)
		else $error("21111");
	reset_hold_a: assert property ($rose(reset_n) |-> port_train_en == 6'h00 && core_global_reset)
		else $error("hold");
	cover property (psel && penable && pslverr);
	cover property (topology_code == 5'h0a && |port_train_en);
	cover property (topology_code == 5'h04 && |port_train_en);
endmodule
bind lts_top lts_chk lts_chk_i(.core_clk, .reset_n, .psel, .penable, .paddr, .pready, .pslverr,
	.topology_code, .core_global_reset, .port_active, .port_train_en);
`default_nettype wire

// ### sim/tb_lane_topology_select.sv
`timescale 1ns/1ns
`default_nettype none
module tb_lane_topology_select;
	// Stimulus, outputs, reference tables
	logic core_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clk_en = 1'b1;
	logic pready, pslverr, er, core_global_reset;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, d, seed = 32'h0001353c;
	logic [2:0] strap_low = 3'h0, pins;
	logic [4:0] topology_code;
	logic [5:0] port_active, port_train_en;
	logic [23:0] port_dev_num, lane_port;
	int err_count = 0, tests_run = 0, k;
	int code[7] = '{11, 1, 2, 12, 10, 4, 0}, pat[8] = '{1, 2, 0, 5, 4, 3, 6, 6};
	logic [53:0] mp[7] = '{54'h3f543210a97654, 54'h03110000000094, 54'h07210000000a94, 54'h07221100000964,
		54'h0f32110000a964, 54'h1f4321000a9764, 54'h00ffffff000000};
	lts_straps lts_straps_i(.strap_low, .pins);
	lts_top lts_top_i(.core_clk, .reset_n, .clk_en, .topology_select_pins(pins), .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .topology_code, .core_global_reset,
		.port_active, .port_train_en, .port_dev_num, .lane_port);
	initial forever #5 core_clk = ~core_clk;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [63:0] s, e, input string n);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic finish_test();
		if (err_count == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// One transfer; the wait for ready is bounded
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 50) begin
			err_count++;
			finish_test();
		end
	endtask
	// Whole output set and both registers against topology i, holds h
	task automatic look(input int i, input logic [31:0] h);
		check({topology_code, port_active, lane_port, port_dev_num}, {5'(code[i]), mp[i]}, "map");
		check({port_train_en, core_global_reset}, {mp[i][53:48] & ~h[26:21] & {6{~h[31]}}, h[31]}, "train");
		apb(1'b0, 12'h020, 32'h0);
		check(rd, h, "link cfg");
		apb(1'b0, 12'h19c, 32'h0);
		check(rd[4:0], code[i], "readback");
	endtask
	initial begin
		for (int p = 0; p < 8; p++) begin
			strap_low <= ~p[2:0];
			reset_n <= 1'b0;
			repeat (20) @(posedge core_clk);
			reset_n <= 1'b1;
			repeat (10) @(posedge core_clk);
			look(pat[p], 32'h07e00000);
			strap_low <= p[2:0];
			d = xs() & 32'h7fffffff;
			apb(1'b1, 12'h020, d | 32'h80000000);
			check(topology_code, code[pat[p]], "straps");
			k = xs() % 6;
			apb(1'b1, 12'h19c, 32'(code[k]));
			apb(1'b1, 12'h020, d);
			repeat (2) @(posedge core_clk);
			look(k, d);
		end
		// Frozen clock enable: reset release must not progress
		clk_en <= 1'b0;
		strap_low <= 3'h5;
		reset_n <= 1'b0;
		repeat (20) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (10) @(posedge core_clk);
		check({topology_code, port_train_en, lane_port, core_global_reset}, {5'h0b, 6'h00, 24'hffffff, 1'b1}, "frozen");
		clk_en <= 1'b1;
		repeat (10) @(posedge core_clk);
		look(pat[2], 32'h07e00000);
		apb(1'b0, 12'h004, 32'h0);
		check({er, rd}, {1'b1, 32'h0}, "unmapped");
		finish_test();
	end
endmodule
`default_nettype wire
